// File: core/dgm_pkg.sv
// Constants, register map and types for the diagnostic status and alarm monitor.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package dgm_pkg;

	// ---------------------------------------------------------------------------
	// Register byte addresses on the serial port.
	// ---------------------------------------------------------------------------
	localparam logic [6:0]  ADDR_ALM1_THR = 7'h20;
	localparam logic [6:0]  ADDR_ALM2_THR = 7'h22;
	localparam logic [6:0]  ADDR_ALM1_CNT = 7'h24;
	localparam logic [6:0]  ADDR_ALM2_CNT = 7'h26;
	localparam logic [6:0]  ADDR_ALARM_CONTROL = 7'h28;
	localparam logic [6:0]  ADDR_MISC     = 7'h34;
	localparam logic [6:0]  ADDR_DIAG     = 7'h3c;
	localparam logic [15:0] REG_RESET     = 16'h0000;

	// ---------------------------------------------------------------------------
	// Field positions.
	// ---------------------------------------------------------------------------
	localparam int DIAG_ALM2    = 9;
	localparam int DIAG_ALM1    = 8;
	localparam int DIAG_MEMFAIL = 6;
	localparam int DIAG_STFAIL  = 5;
	localparam int DIAG_OVR     = 4;
	localparam int DIAG_SPIFAIL = 3;
	localparam int DIAG_FLASH   = 2;
	localparam int DIAG_SUPHI   = 1;
	localparam int DIAG_SUPLO   = 0;
	localparam logic [9:0] STICKY_MASK = 10'h37c;
	localparam int CTRL_ROC2    = 15;
	localparam int CTRL_SRC2_LO = 12;
	localparam int CTRL_ROC1    = 11;
	localparam int CTRL_SRC1_LO = 8;
	localparam int CTRL_FILT    = 4;
	localparam int CTRL_OUT_EN  = 2;
	localparam int CTRL_OUT_POL = 1;
	localparam int CTRL_OUT_SEL = 0;
	localparam int MISC_MEMTEST = 11;
	localparam int THR_GT       = 15;
	localparam int FRAME_RW     = 15;
	localparam int FRAME_BITS   = 16;

	// ---------------------------------------------------------------------------
	// Source codes, supply limits, memory test span.
	// ---------------------------------------------------------------------------
	localparam logic [2:0] SRC_OFF    = 3'h0;
	localparam logic [2:0] SRC_SUPPLY = 3'h1;
	localparam logic [2:0] SRC_GYRO   = 3'h2;
	localparam logic [2:0] SRC_AUX    = 3'h5;
	localparam logic [2:0] SRC_TEMP   = 3'h6;
	localparam int SUPPLY_HIGH_MV = 5250;
	localparam int SUPPLY_LOW_MV  = 4750;
	localparam int SUPPLY_LSB_UV  = 2000;
	localparam logic [13:0] SUPPLY_HIGH_CODE = 14'(SUPPLY_HIGH_MV * 1000 / SUPPLY_LSB_UV);
	localparam logic [13:0] SUPPLY_LOW_CODE  = 14'(SUPPLY_LOW_MV * 1000 / SUPPLY_LSB_UV);
	localparam int MEM_WORDS = 64;
	localparam logic [5:0] MEM_LAST = 6'(MEM_WORDS - 1);

	typedef enum logic [2:0] {
		MT_IDLE = 3'b001,
		MT_RUN  = 3'b010,
		MT_DONE = 3'b100
	} dgm_mt_state_type;

endpackage : dgm_pkg

// File: core/dgm_spi_slave.sv
// Serial register port: oversampled 16-bit frames, sclk idles high.
`timescale 1ns/10ps
module dgm_spi_slave (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Serial pins.
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic        din_in,
	output logic             dout_out,
	output logic             dout_oe_out,
	// Frame side.
	input  wire logic [15:0] load_word_in,
	output logic             frame_out,
	output logic [15:0]      word_out,
	output logic             frame_err_out
);
	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic        sclk_d1_q;
	logic        cs_d1_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic [4:0]  cnt_q;

	// Two flip-flops on every pin before any logic looks at it.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync1_q <= 3'h6; // Idle pin levels: sclk high, cs high, din low, so no false edge follows reset.
			sync2_q <= 3'h6;
		end else begin
			sync1_q <= {sclk_in, cs_n_in, din_in};
			sync2_q <= sync1_q;
		end
	end

	wire sclk_s = sync2_q[2];
	wire cs_s   = sync2_q[1];
	wire din_s  = sync2_q[0];
	wire rise   = sclk_s & ~sclk_d1_q & ~cs_s;
	wire fall   = ~sclk_s & sclk_d1_q & ~cs_s;
	wire cs_fall = ~cs_s & cs_d1_q;
	wire cs_rise = cs_s & ~cs_d1_q;
	wire full   = (cnt_q == 5'(dgm_pkg::FRAME_BITS));

	// Shift in on rising edges, out on falling edges after the first bit.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sclk_d1_q <= 1'b1;
			cs_d1_q   <= 1'b1;
			rx_q      <= 16'h0000;
			tx_q      <= 16'h0000;
			cnt_q     <= 5'h00;
		end else begin
			sclk_d1_q <= sclk_s;
			cs_d1_q   <= cs_s;
			if (cs_fall) begin
				tx_q  <= load_word_in;
				cnt_q <= 5'h00;
			end else begin
				if (rise && !full) begin
					rx_q  <= {rx_q[14:0], din_s};
					cnt_q <= cnt_q + 5'h01;
				end
				if (fall && cnt_q != 5'h00)
					tx_q <= {tx_q[14:0], 1'b0};
			end
		end
	end

	// A frame that ends after one to fifteen bits is a communication failure.
	assign frame_out     = cs_rise & full;
	assign frame_err_out = cs_rise & ~full & (cnt_q != 5'h00);
	assign word_out      = rx_q;
	assign dout_out      = tx_q[15];
	assign dout_oe_out   = ~cs_s;

endmodule : dgm_spi_slave

// File: core/dgm_alarm_unit.sv
// One alarm channel: static level or rate-of-change comparison.
`timescale 1ns/10ps
module dgm_alarm_unit (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Sample stream and settings.
	input  wire logic        sample_in,
	input  wire logic        enable_in,
	input  wire logic        roc_in,
	input  wire logic        signed_in,
	input  wire logic [13:0] value_in,
	input  wire logic [15:0] threshold_in,
	input  wire logic [7:0]  count_in,
	// Result.
	output logic             active_out
);
	logic [13:0] hist_mem [0:255];
	logic [7:0]  wr_ptr_q;
	logic [8:0]  fill_q;
	logic        active_q;

	// Threshold test shared by both modes; level operands are sign extended for signed sources, rate magnitudes compare unsigned.
	function automatic logic exceeds(input logic [14:0] a, input logic [14:0] b, input logic sgn,
			input logic gt);
		logic hi;
		logic lo;
		hi = sgn ? ($signed(a) > $signed(b)) : (a > b);
		lo = sgn ? ($signed(a) < $signed(b)) : (a < b);
		return gt ? hi : lo;
	endfunction : exceeds

	wire [7:0]  win     = (count_in <= 8'h01) ? 8'h01 : count_in;
	wire [7:0]  past_ix = wr_ptr_q - win;
	wire [13:0] past    = hist_mem[past_ix];
	wire [14:0] cur_x   = {signed_in & value_in[13], value_in};
	wire [14:0] past_x  = {signed_in & past[13], past};
	wire [14:0] thr_x   = {signed_in & threshold_in[13], threshold_in[13:0]};
	wire [14:0] diff    = cur_x - past_x;
	wire [14:0] mag     = diff[14] ? 15'(~diff + 15'h0001) : diff;
	wire        ready   = fill_q >= {1'b0, win};
	wire        roc_hit = ready & exceeds(mag, {1'b0, threshold_in[13:0]}, 1'b0, threshold_in[dgm_pkg::THR_GT]);
	wire        lvl_hit = exceeds(cur_x, thr_x, signed_in, threshold_in[dgm_pkg::THR_GT]);
	wire        hit     = roc_in ? roc_hit : lvl_hit;

	// History ring holds one entry per sample; no reset needed on data.
	always_ff @(posedge clk_in) begin
		if (sample_in)
			hist_mem[wr_ptr_q] <= value_in;
	end

	// Verdict changes only on samples; disabling clears it at once.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_q <= 8'h00;
			fill_q   <= 9'h000;
			active_q <= 1'b0;
		end else begin
			if (sample_in) begin
				wr_ptr_q <= wr_ptr_q + 8'h01;
				if (fill_q != 9'h100)
					fill_q <= fill_q + 9'h001;
			end
			if (!enable_in)
				active_q <= 1'b0;
			else if (sample_in)
				active_q <= hit;
		end
	end

	assign active_out = active_q;

	a_disabled_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!enable_in |=> !active_out) else $error("alarm active while disabled");
	a_static_verdict: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(sample_in && enable_in && !roc_in) |=> (active_out == $past(lvl_hit)))
		else $error("static verdict wrong");

endmodule : dgm_alarm_unit

// File: core/dgm_diag_alarm_top.sv
// Diagnostic status register, memory test and dual alarm monitor behind the serial port.
`timescale 1ns/10ps
module dgm_diag_alarm_top (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Serial register port.
	input  wire logic        spi_sclk_in,
	input  wire logic        spi_cs_n_in,
	input  wire logic        spi_din_in,
	output logic             spi_dout_out,
	output logic             spi_dout_oe_out,
	// Sample stream.
	input  wire logic        sample_strobe_in,
	input  wire logic [13:0] supply_code_in,
	input  wire logic [13:0] gyro_raw_in,
	input  wire logic [13:0] gyro_filt_in,
	input  wire logic [13:0] aux_adc_in,
	input  wire logic [13:0] temp_in,
	// Error conditions.
	input  wire logic        overrange_in,
	input  wire logic        selftest_fail_in,
	input  wire logic        flash_update_fail_in,
	// Memory test read ports.
	output logic [5:0]       mem_addr_out,
	input  wire logic [15:0] flash_word_in,
	input  wire logic [15:0] sram_word_in,
	// Alarm indicator lines.
	output logic             digital_line_one_out,
	output logic             digital_line_one_oe_out,
	output logic             digital_line_two_out,
	output logic             digital_line_two_oe_out
);
	logic [15:0] alarm_one_threshold_q;
	logic [15:0] alarm_two_threshold_q;
	logic [15:0] alarm_one_sample_count_q;
	logic [15:0] alarm_two_sample_count_q;
	logic [15:0] alarm_control_q;
	logic        memtest_q;
	logic        mem_fail_q;
	logic [9:0]  sticky_q;
	logic [1:0]  supply_q;
	logic [15:0] rd_word_q;
	logic [15:0] sum_flash_q;
	logic [15:0] sum_sram_q;
	logic [5:0]  mem_addr_q;
	logic [1:0]  lines_q;
	logic [1:0]  lines_oe_q;
	dgm_pkg::dgm_mt_state_type mt_state_q;
	dgm_pkg::dgm_mt_state_type mt_state_d;
	logic        frame;
	logic        frame_err;
	logic [15:0] frame_word;
	logic        alm1_act;
	logic        alm2_act;

	// ---------------------------------------------------------------------------
	// Helpers for register byte writes and for both alarm channels.
	// ---------------------------------------------------------------------------
	// Merge one written byte into a 16-bit register; odd address is the upper byte.
	function automatic logic [15:0] merge(input logic [15:0] old, input logic odd, input logic [7:0] b);
		return odd ? {b, old[7:0]} : {old[15:8], b};
	endfunction : merge

	// Source mux; only the gyro has a filtered version to choose from.
	// Every source is an argument, so a change of any of them re-evaluates the mux.
	function automatic logic [13:0] pick(input logic [2:0] code, input logic use_filt, input logic [13:0] sup,
			input logic [13:0] graw, input logic [13:0] gflt, input logic [13:0] aux, input logic [13:0] tmp);
		unique case (code)
			dgm_pkg::SRC_SUPPLY: return sup;
			dgm_pkg::SRC_GYRO:   return use_filt ? gflt : graw;
			dgm_pkg::SRC_AUX:    return aux;
			dgm_pkg::SRC_TEMP:   return tmp;
			default:             return 14'h0000;
		endcase
	endfunction : pick

	function automatic logic src_ok(input logic [2:0] code);
		return code == dgm_pkg::SRC_SUPPLY || code == dgm_pkg::SRC_GYRO ||
			code == dgm_pkg::SRC_AUX || code == dgm_pkg::SRC_TEMP;
	endfunction : src_ok

	// Gyro and temperature are two's complement; supply and ADC are plain binary.
	function automatic logic src_signed(input logic [2:0] code);
		return code == dgm_pkg::SRC_GYRO || code == dgm_pkg::SRC_TEMP;
	endfunction : src_signed

	// ---------------------------------------------------------------------------
	// Serial port and frame decode.
	// ---------------------------------------------------------------------------
	dgm_spi_slave u_spi (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.sclk_in       (spi_sclk_in),
		.cs_n_in       (spi_cs_n_in),
		.din_in        (spi_din_in),
		.dout_out      (spi_dout_out),
		.dout_oe_out   (spi_dout_oe_out),
		.load_word_in  (rd_word_q),
		.frame_out     (frame),
		.word_out      (frame_word),
		.frame_err_out (frame_err)
	);

	wire [6:0]  f_addr  = frame_word[14:8];
	wire [6:0]  f_word  = {f_addr[6:1], 1'b0};
	wire        f_odd   = f_addr[0];
	wire        wr      = frame & frame_word[dgm_pkg::FRAME_RW];
	wire        rd      = frame & ~frame_word[dgm_pkg::FRAME_RW];
	wire        wr_thr1 = wr && f_word == dgm_pkg::ADDR_ALM1_THR;
	wire        wr_thr2 = wr && f_word == dgm_pkg::ADDR_ALM2_THR;
	wire        wr_cnt1 = wr && f_word == dgm_pkg::ADDR_ALM1_CNT;
	wire        wr_cnt2 = wr && f_word == dgm_pkg::ADDR_ALM2_CNT;
	wire        wr_ctrl = wr && f_word == dgm_pkg::ADDR_ALARM_CONTROL;
	wire        wr_misc = wr && f_word == dgm_pkg::ADDR_MISC;
	wire        diag_clr = rd && f_word == dgm_pkg::ADDR_DIAG;
	wire [15:0] misc_wv = merge(16'h0000, f_odd, frame_word[7:0]);
	wire [15:0] diag_rv = {6'h00, sticky_q[9:2], supply_q};
	wire [15:0] misc_rv = {4'h0, memtest_q, 11'h000};
	wire [15:0] rd_mux  =
		(f_word == dgm_pkg::ADDR_ALM1_THR) ? alarm_one_threshold_q :
		(f_word == dgm_pkg::ADDR_ALM2_THR) ? alarm_two_threshold_q :
		(f_word == dgm_pkg::ADDR_ALM1_CNT) ? alarm_one_sample_count_q :
		(f_word == dgm_pkg::ADDR_ALM2_CNT) ? alarm_two_sample_count_q :
		(f_word == dgm_pkg::ADDR_ALARM_CONTROL) ? alarm_control_q :
		(f_word == dgm_pkg::ADDR_MISC)     ? misc_rv :
		(f_word == dgm_pkg::ADDR_DIAG)     ? diag_rv : 16'h0000;

	// Configuration registers, byte writable; the sample count keeps only its low byte.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			alarm_one_threshold_q    <= dgm_pkg::REG_RESET;
			alarm_two_threshold_q    <= dgm_pkg::REG_RESET;
			alarm_one_sample_count_q <= dgm_pkg::REG_RESET;
			alarm_two_sample_count_q <= dgm_pkg::REG_RESET;
			alarm_control_q          <= dgm_pkg::REG_RESET;
			rd_word_q                <= dgm_pkg::REG_RESET;
		end else begin
			if (wr_thr1) alarm_one_threshold_q <= merge(alarm_one_threshold_q, f_odd, frame_word[7:0]);
			if (wr_thr2) alarm_two_threshold_q <= merge(alarm_two_threshold_q, f_odd, frame_word[7:0]);
			if (wr_cnt1 && !f_odd) alarm_one_sample_count_q <= {8'h00, frame_word[7:0]};
			if (wr_cnt2 && !f_odd) alarm_two_sample_count_q <= {8'h00, frame_word[7:0]};
			if (wr_ctrl) alarm_control_q <= merge(alarm_control_q, f_odd, frame_word[7:0]);
			if (rd) rd_word_q <= rd_mux;
		end
	end

	// ---------------------------------------------------------------------------
	// Memory test: walk both memories, sum each, compare the sums.
	// ---------------------------------------------------------------------------
	wire mt_start = mt_state_q == dgm_pkg::MT_IDLE && memtest_q;
	wire mt_last  = mt_state_q == dgm_pkg::MT_RUN && mem_addr_q == dgm_pkg::MEM_LAST;
	wire mt_done  = mt_state_q == dgm_pkg::MT_DONE;

	always_comb begin
		mt_state_d = mt_state_q;
		unique case (mt_state_q)
			dgm_pkg::MT_IDLE: if (mt_start) mt_state_d = dgm_pkg::MT_RUN;
			dgm_pkg::MT_RUN:  if (mt_last) mt_state_d = dgm_pkg::MT_DONE;
			dgm_pkg::MT_DONE: mt_state_d = dgm_pkg::MT_IDLE;
		endcase
	end

	// The control bit stays set until the comparison finishes; writing zero cannot abort.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mt_state_q  <= dgm_pkg::MT_IDLE;
			memtest_q   <= 1'b0;
			mem_fail_q  <= 1'b0;
			mem_addr_q  <= 6'h00;
			sum_flash_q <= 16'h0000;
			sum_sram_q  <= 16'h0000;
		end else begin
			mt_state_q <= mt_state_d;
			if (mt_done)
				memtest_q <= 1'b0;
			else if (wr_misc && misc_wv[dgm_pkg::MISC_MEMTEST])
				memtest_q <= 1'b1;
			if (mt_start) begin
				mem_addr_q  <= 6'h00;
				sum_flash_q <= 16'h0000;
				sum_sram_q  <= 16'h0000;
			end else if (mt_state_q == dgm_pkg::MT_RUN) begin
				mem_addr_q  <= mem_addr_q + 6'h01;
				sum_flash_q <= sum_flash_q + flash_word_in;
				sum_sram_q  <= sum_sram_q + sram_word_in;
			end
			if (mt_done)
				mem_fail_q <= sum_flash_q != sum_sram_q;
		end
	end

	assign mem_addr_out = mem_addr_q;

	// ---------------------------------------------------------------------------
	// Alarm channels.
	// ---------------------------------------------------------------------------
	wire [2:0] src1 = alarm_control_q[dgm_pkg::CTRL_SRC1_LO +: 3];
	wire [2:0] src2 = alarm_control_q[dgm_pkg::CTRL_SRC2_LO +: 3];
	wire       filt = alarm_control_q[dgm_pkg::CTRL_FILT];
	wire [13:0] val1 = pick(src1, filt, supply_code_in, gyro_raw_in, gyro_filt_in, aux_adc_in, temp_in);
	wire [13:0] val2 = pick(src2, filt, supply_code_in, gyro_raw_in, gyro_filt_in, aux_adc_in, temp_in);

	// Each channel carries its own threshold, count, source and mode.
	dgm_alarm_unit u_alarm_one (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.sample_in    (sample_strobe_in),
		.enable_in    (src_ok(src1)),
		.roc_in       (alarm_control_q[dgm_pkg::CTRL_ROC1]),
		.signed_in    (src_signed(src1)),
		.value_in     (val1),
		.threshold_in (alarm_one_threshold_q),
		.count_in     (alarm_one_sample_count_q[7:0]),
		.active_out   (alm1_act)
	);

	dgm_alarm_unit u_alarm_two (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.sample_in    (sample_strobe_in),
		.enable_in    (src_ok(src2)),
		.roc_in       (alarm_control_q[dgm_pkg::CTRL_ROC2]),
		.signed_in    (src_signed(src2)),
		.value_in     (val2),
		.threshold_in (alarm_two_threshold_q),
		.count_in     (alarm_two_sample_count_q[7:0]),
		.active_out   (alm2_act)
	);

	// ---------------------------------------------------------------------------
	// Status flags and indicator lines.
	// ---------------------------------------------------------------------------
	wire [9:0] cond = {alm2_act, alm1_act, 1'b0, mem_fail_q, selftest_fail_in, overrange_in,
		1'b0, flash_update_fail_in, 2'b00};
	wire [9:0] spi_set = {6'h00, frame_err, 3'h0};
	wire [9:0] set_v   = ((sample_strobe_in ? cond : 10'h000) | spi_set) & dgm_pkg::STICKY_MASK;
	wire [9:0] keep_v  = diag_clr ? 10'h000 : sticky_q;
	wire       ind     = alm1_act | alm2_act;
	wire       out_en  = alarm_control_q[dgm_pkg::CTRL_OUT_EN];
	wire       out_sel = alarm_control_q[dgm_pkg::CTRL_OUT_SEL];
	wire       lvl     = alarm_control_q[dgm_pkg::CTRL_OUT_POL] ? ind : ~ind;

	// A set in the same cycle as a read clear wins, so no event is lost.
	// Supply flags follow the supply directly and are untouched by reads.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sticky_q   <= 10'h000;
			supply_q   <= 2'b00;
			lines_q    <= 2'h0;
			lines_oe_q <= 2'h0;
		end else begin
			sticky_q <= keep_v | set_v;
			supply_q <= {supply_code_in > dgm_pkg::SUPPLY_HIGH_CODE, supply_code_in < dgm_pkg::SUPPLY_LOW_CODE};
			lines_q    <= {lvl, lvl};
			lines_oe_q <= {out_en & out_sel, out_en & ~out_sel};
		end
	end

	assign digital_line_one_out    = lines_q[0];
	assign digital_line_one_oe_out = lines_oe_q[0];
	assign digital_line_two_out    = lines_q[1];
	assign digital_line_two_oe_out = lines_oe_q[1];

	// ---------------------------------------------------------------------------
	// Checks.
	// ---------------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_memtest_clears: assert property (mt_start |-> ##65 mt_done ##1 !memtest_q)
		else $error("memory test bit did not clear");
	a_memtest_result: assert property (mt_done |=> mem_fail_q == $past(sum_flash_q != sum_sram_q))
		else $error("memory test result wrong");
	a_memflag_sets: assert property ((sample_strobe_in && mem_fail_q) |=> sticky_q[dgm_pkg::DIAG_MEMFAIL])
		else $error("checksum flag not set");
	a_read_clears: assert property ((diag_clr && !sample_strobe_in && !frame_err) |=> sticky_q == 10'h000)
		else $error("status read did not clear flags");
	a_flag_returns: assert property ((diag_clr && sample_strobe_in && overrange_in)
		|=> sticky_q[dgm_pkg::DIAG_OVR]) else $error("overrange flag lost on read");
	a_supply_kept: assert property ((diag_clr && supply_code_in > dgm_pkg::SUPPLY_HIGH_CODE)
		|=> supply_q[1]) else $error("supply flag cleared by read");
	a_supply_low: assert property ((supply_code_in < dgm_pkg::SUPPLY_LOW_CODE) |=> supply_q[0])
		else $error("supply low flag wrong");
	a_supply_track: assert property ($past(supply_code_in >= dgm_pkg::SUPPLY_LOW_CODE) |-> !supply_q[0])
		else $error("supply low flag stuck");
	a_alarm_status: assert property ((sample_strobe_in && alm1_act) |=> sticky_q[dgm_pkg::DIAG_ALM1])
		else $error("alarm one status missing");
	a_spi_fail: assert property (frame_err |=> sticky_q[dgm_pkg::DIAG_SPIFAIL])
		else $error("communication failure not flagged");
	a_line_select: assert property ((out_en && out_sel) |=> digital_line_two_oe_out && !digital_line_one_oe_out)
		else $error("indicator on wrong line");
	a_source_unused: assert property ((src1 == 3'h3) |=> !alm1_act)
		else $error("alarm active on unused source");

	c_memtest_run: cover property (mt_start ##[1:80] mt_done);
	c_status_read: cover property (diag_clr && sticky_q != 10'h000);
	c_alarm_rate: cover property (alm2_act && alarm_control_q[dgm_pkg::CTRL_ROC2]);
	c_memtest_fail: cover property (mt_done && sum_flash_q != sum_sram_q);
	c_line_two: cover property (digital_line_two_oe_out && digital_line_two_out);

endmodule : dgm_diag_alarm_top

// File: dv/dgm_host_model.sv
// Host serial master model for the register port.
`timescale 1ns/10ps
module dgm_host_model (
	// Serial pins.
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      din_out,
	input  wire logic dout_in
);
	// Idle bus: clock high and chip deselected.
	initial begin
		sclk_out = 1'h1;
		cs_n_out = 1'h1;
		din_out = 1'h0;
	end
	// One frame of n bits, MSB first; din changes after sclk falls and dout is taken at the rise.
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0000;
		cs_n_out = 1'h0;
		#230;
		for (int i = 15; i > 15 - n; i--) begin
			sclk_out = 1'h0;
			din_out = w[i];
			#200;
			sclk_out = 1'h1;
			r[i] = dout_in;
			#200;
		end
		cs_n_out = 1'h1;
		din_out = ~din_out; // A released line must not keep showing the last bit.
		#430;
	endtask : xfer
endmodule : dgm_host_model

// File: dv/tb_top.sv
// Self-checking bench for the diagnostic status and alarm monitor.
`timescale 1ns/10ps
module tb_top;
	typedef struct packed {logic [13:0] sup; logic [13:0] gyr; logic [9:0] flags; logic line;} dgm_row_type;
	logic        clk_in = 1'h0;
	logic        rst_n_in = 1'h0;
	logic        strobe = 1'h0;
	logic        ovr = 1'h0;
	logic        bad = 1'h0;
	logic [13:0] supply = 14'h09c4;
	logic [13:0] gyro = 14'h0000;
	logic [13:0] raw = 14'h0000;
	logic [15:0] rd;
	logic [5:0]  maddr;
	logic        sclk, cs_n, din, dout, dout_oe, l1, l1_oe, l2, l2_oe;
	int          errors = 0;
	int          checked = 0;
	// Supply code, filtered rate, expected flags and line level; edges of both supply limits.
	dgm_row_type rows [5] = '{'{14'h09c4, 14'h00c8, 10'h100, 1'h1}, '{14'h0a42, 14'h0032, 10'h002, 1'h0},
		'{14'h0946, 14'h0065, 10'h101, 1'h1}, '{14'h0a41, 14'h0064, 10'h000, 1'h0},
		'{14'h0947, 14'h3ffb, 10'h000, 1'h0}};

	dgm_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));
	dgm_diag_alarm_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
		.spi_din_in(din), .spi_dout_out(dout), .spi_dout_oe_out(dout_oe), .sample_strobe_in(strobe),
		.supply_code_in(supply), .gyro_raw_in(raw), .gyro_filt_in(gyro), .aux_adc_in(14'h0000),
		.temp_in(14'h0000), .overrange_in(ovr), .selftest_fail_in(1'h0), .flash_update_fail_in(1'h0),
		.mem_addr_out(maddr), .flash_word_in({10'h000, maddr} + {15'h0000, bad}), .sram_word_in({10'h000, maddr}),
		.digital_line_one_out(l1), .digital_line_one_oe_out(l1_oe), .digital_line_two_out(l2),
		.digital_line_two_oe_out(l2_oe));

	// Free-running 20 MHz clock.
	always #25 clk_in = ~clk_in;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check
	// A read answers in the following frame, so the second frame asks for a harmless register.
	task automatic rdreg(input logic [6:0] a);
		logic [15:0] r;
		host.xfer({1'h0, a, 8'h00}, 16, r);
		host.xfer({1'h0, dgm_pkg::ADDR_MISC, 8'h00}, 16, rd);
	endtask : rdreg
	task automatic wrreg(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] r;
		host.xfer({1'h1, a, v[7:0]}, 16, r);
		host.xfer({1'h1, a | 7'h01, v[15:8]}, 16, r);
	endtask : wrreg
	task automatic pulse;
		@(negedge clk_in) strobe = 1'h1;
		@(negedge clk_in) strobe = 1'h0;
		repeat (3) @(negedge clk_in);
	endtask : pulse
	task automatic print_verdict;
		if (errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict

	// Watchdog sized well beyond the roughly 60 frames of the sequence.
	initial begin
		#2000000;
		errors++;
		print_verdict();
	end

	// Main sequence: table rows first, then clear-on-read, frame error and memory test.
	initial begin
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'h1;
		rdreg(dgm_pkg::ADDR_ALARM_CONTROL);
		check(rd, dgm_pkg::REG_RESET);
		wrreg(dgm_pkg::ADDR_ALM1_THR, 16'h8064); // Greater than 100.
		wrreg(dgm_pkg::ADDR_ALARM_CONTROL, 16'h0216); // Gyro filtered, line one, active high.
		foreach (rows[i]) begin
			@(negedge clk_in);
			supply = rows[i].sup;
			gyro = rows[i].gyr;
			pulse();
			pulse();
			rdreg(dgm_pkg::ADDR_DIAG);
			pulse();
			rdreg(dgm_pkg::ADDR_DIAG);
			check(rd, {6'h00, rows[i].flags});
			check({13'h0000, l2_oe, l1_oe, l1}, {15'h0001, rows[i].line});
		end
		@(negedge clk_in);
		ovr = 1'h1;
		supply = 14'h0a42;
		pulse();
		rdreg(dgm_pkg::ADDR_DIAG);
		check(rd, 16'h0012);
		rdreg(dgm_pkg::ADDR_DIAG);
		check(rd, 16'h0002);
		pulse();
		rdreg(dgm_pkg::ADDR_DIAG);
		check(rd, 16'h0012);
		@(negedge clk_in);
		ovr = 1'h0;
		supply = 14'h09c4;
		host.xfer(16'hffff, 5, rd);
		rdreg(dgm_pkg::ADDR_DIAG);
		check(rd, 16'h0008);
		// Failing test first, so the passing one must clear the result.
		for (int b = 1; b >= 0; b--) begin
			@(negedge clk_in);
			bad = b[0];
			wrreg(dgm_pkg::ADDR_MISC, 16'h0800);
			rdreg(dgm_pkg::ADDR_MISC);
			check(rd, 16'h0000);
			pulse();
			rdreg(dgm_pkg::ADDR_DIAG);
			check(rd, b[0] ? 16'h0040 : 16'h0000);
		end
		// Rate of change on alarm two from raw data, line two active low; a zero count means one sample.
		wrreg(dgm_pkg::ADDR_ALM2_THR, 16'h8032);
		wrreg(dgm_pkg::ADDR_ALARM_CONTROL, 16'ha005);
		pulse();
		raw = 14'h0064;
		pulse();
		check({13'h0000, l2_oe, l1_oe, l2}, 16'h0004);
		pulse();
		check({13'h0000, l2_oe, l1_oe, l2}, 16'h0005);
		rdreg(dgm_pkg::ADDR_DIAG);
		check(rd, 16'h0200);
		// Static less-than on signed filtered data, then an unused source code on alarm one.
		wrreg(dgm_pkg::ADDR_ALM1_THR, 16'h0064);
		wrreg(dgm_pkg::ADDR_ALARM_CONTROL, 16'h0217);
		pulse();
		check({13'h0000, l2_oe, l1_oe, l2}, 16'h0005);
		wrreg(dgm_pkg::ADDR_ALARM_CONTROL, 16'h0317);
		pulse();
		check({13'h0000, l2_oe, l1_oe, l2}, 16'h0004);
		// A reset in mid-run must bring lines and registers back to their reset values.
		@(negedge clk_in);
		rst_n_in = 1'h0;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'h1;
		check({13'h0000, l2_oe, l1_oe, l2}, 16'h0000);
		rdreg(dgm_pkg::ADDR_ALARM_CONTROL);
		check(rd, dgm_pkg::REG_RESET);
		print_verdict();
	end
endmodule : tb_top
